// *** rtl/fasc_bus_cycle.v ***
// Purpose: one read or write cycle on the flash pins
// Assumes: strobes held for a fixed number of clocks
// Notes:   data output enable is active low while driving
`include "fasc_regs.vh"
module fasc_bus_cycle #(
  parameter AW   = 19,
  parameter HOLD = `FASC_ACCESS_CYC
) (
  input  wire          ref_clk,
  input  wire          reset,
  input  wire          start,
  input  wire          is_write,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire [7:0]    dq_in,
  output reg           busy,
  output reg           done,
  output reg  [7:0]    rdata,
  output reg  [AW-1:0] addr_out,
  output reg  [7:0]    dq_out,
  output reg           dq_oe_n,
  output reg           cs_n,
  output reg           oe_n,
  output reg           we_n
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ACT  = 2'h1;
  localparam [1:0] S_END  = 2'h2;
  localparam [7:0] HOLD_C = HOLD[7:0];
  reg [1:0] state_reg;
  reg [7:0] cnt_reg;
  reg       wr_reg;
  always @(posedge ref_clk) begin
    done <= 1'b0;
    if (reset) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 8'h00;
      wr_reg    <= 1'b0;
      busy      <= 1'b0;
      rdata     <= 8'h00;
      addr_out  <= {AW{1'b0}};
      dq_out    <= 8'h00;
      dq_oe_n   <= 1'b1;
      cs_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            busy      <= 1'b1;
            wr_reg    <= is_write;
            addr_out  <= addr;
            dq_out    <= wdata;
            cs_n      <= 1'b0;
            // [R15] [R16] write: strobe and select low, gate high
            oe_n      <= is_write;
            we_n      <= ~is_write;
            dq_oe_n   <= ~is_write;
            cnt_reg   <= HOLD_C;
            state_reg <= S_ACT;
          end
        end
        S_ACT: begin
          if (cnt_reg <= 8'h01) begin
            // data sampled before the strobes rise
            if (!wr_reg)
              rdata <= dq_in;
            cs_n      <= 1'b1;
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            state_reg <= S_END;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_END: begin
          // keep data one clock past the strobe for hold time
          dq_oe_n   <= 1'b1;
          busy      <= 1'b0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// *** rtl/fasc_host.v ***
// Operation
// [R1] in identification mode reads return an 8-bit code, not array data
// [R2] high-voltage entry needs A9 at hv level, A6 low, A1:A0 select
// [R3] id entry writes AA@555, 55@2AA, 90@555, then id reads
// [R4] A1 low: A0 low manufacturer code, A0 high device code
// [R5] A1 high A0 low verify read returns 01 protected, 00 not
// [R6] host puts sector bits on top address lines when verifying
// [R7] sector selection comes from address bits 18 down to 13
// [R8] program writes AA@555, 55@2AA, A0@555, then address and byte
// [R9] sector erase is six writes ending with 30 to sector address
// [R10] suspend B0 and resume 30 only during sector erase
// [R11] broken sequence returns flash to array read
// [R12] command addresses use only bits 11 to 0
// [R13] single F0 write returns flash to array read
// [R14] chip erase ends with 10 written to 555
// [R15] read: select and gate low, write strobe high
// [R16] write: strobe and select low, gate high
// [R17] identification stays until the read reset command
// Purpose: host controller issuing flash command sequences
// Assumes: one request at a time, taken while ready is high
// Notes:   embedded operation completion is not polled here
`include "fasc_regs.vh"
module fasc_host #(
  parameter AW   = 19,
  parameter HOLD = `FASC_ACCESS_CYC
) (
  input  wire          ref_clk,
  input  wire          reset,
  input  wire          req_valid,
  input  wire [2:0]    req_op,
  input  wire [AW-1:0] req_addr,
  input  wire [7:0]    req_data,
  input  wire          req_read,
  input  wire          req_hv_id,
  input  wire [7:0]    dq_in,
  output reg           ready,
  output reg           resp_valid,
  output reg  [7:0]    resp_data,
  output reg           resp_refused,
  output reg           id_mode,
  output reg           erase_active,
  output wire [AW-1:0] flash_addr,
  output wire [7:0]    dq_out,
  output wire          dq_oe_n,
  output wire          cs_n,
  output wire          oe_n,
  output wire          we_n,
  output reg           hv_level
);
  localparam [1:0] H_IDLE = 2'h0;
  localparam [1:0] H_SEQ  = 2'h1;
  localparam [1:0] H_WAIT = 2'h2;
  reg  [1:0]    state_reg;
  reg  [2:0]    step_reg;
  reg  [2:0]    nsteps_reg;
  reg  [2:0]    op_reg;
  reg  [AW-1:0] addr_reg;
  reg  [7:0]    data_reg;
  reg           rd_reg;
  reg           suspended_reg;
  reg           start_reg;
  reg           cyc_wr_reg;
  reg  [AW-1:0] cyc_addr_reg;
  reg  [7:0]    cyc_data_reg;
  wire          cyc_busy;
  wire          cyc_done;
  wire [7:0]    cyc_rdata;

  // command addresses carry only the low twelve bits
  function [AW-1:0] cmd_addr;
    input [11:0] a;
    begin
      cmd_addr = {{(AW-12){1'b0}}, a};
    end
  endfunction

  // sequence step table: {address, data} of write number s
  function [AW+7:0] step_word;
    input [2:0]    op;
    input [2:0]    s;
    input [AW-1:0] a;
    input [7:0]    d;
    begin
      case (s)
        3'h0: step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_UNLOCK_DATA1};
        3'h1: step_word = {cmd_addr(`FASC_UNLOCK_ADDR2), `FASC_UNLOCK_DATA2};
        3'h2: begin
          case (op)
            `FASC_OP_PROGRAM:
              step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_CMD_PROGRAM};
            `FASC_OP_AUTOSEL:
              step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_CMD_AUTOSEL};
            default:
              step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_CMD_ERASE_SET};
          endcase
        end
        3'h3: begin
          if (op == `FASC_OP_PROGRAM)
            step_word = {a, d};
          else
            step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_UNLOCK_DATA1};
        end
        3'h4: step_word = {cmd_addr(`FASC_UNLOCK_ADDR2), `FASC_UNLOCK_DATA2};
        default: begin
          if (op == `FASC_OP_CHIP_ERASE)
            step_word = {cmd_addr(`FASC_UNLOCK_ADDR1), `FASC_CMD_CHIP_ERASE};
          else
            step_word = {a, `FASC_CMD_SECT_ERASE};
        end
      endcase
    end
  endfunction

  // id read address: sector bits kept, function bits in A1:A0
  function [AW-1:0] id_addr;
    input [AW-1:0] a;
    reg   [AW-1:0] m;
    begin
      m = {AW{1'b0}};
      m[`FASC_SECT_MSB:`FASC_SECT_LSB] = a[`FASC_SECT_MSB:`FASC_SECT_LSB];
      m[1:0] = a[1:0];
      id_addr = m;
    end
  endfunction

  wire [AW+7:0] cur_step = step_word(op_reg, step_reg, addr_reg, data_reg);

  fasc_bus_cycle #(
    .AW   (AW),
    .HOLD (HOLD)
  ) u_cycle (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .start    (start_reg),
    .is_write (cyc_wr_reg),
    .addr     (cyc_addr_reg),
    .wdata    (cyc_data_reg),
    .dq_in    (dq_in),
    .busy     (cyc_busy),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .addr_out (flash_addr),
    .dq_out   (dq_out),
    .dq_oe_n  (dq_oe_n),
    .cs_n     (cs_n),
    .oe_n     (oe_n),
    .we_n     (we_n)
  );

  always @(posedge ref_clk) begin
    start_reg    <= 1'b0;
    resp_valid   <= 1'b0;
    resp_refused <= 1'b0;
    if (reset) begin
      state_reg     <= H_IDLE;
      step_reg      <= 3'h0;
      nsteps_reg    <= 3'h0;
      op_reg        <= `FASC_OP_READ;
      addr_reg      <= {AW{1'b0}};
      data_reg      <= 8'h00;
      rd_reg        <= 1'b0;
      suspended_reg <= 1'b0;
      cyc_wr_reg    <= 1'b0;
      cyc_addr_reg  <= {AW{1'b0}};
      cyc_data_reg  <= 8'h00;
      ready         <= 1'b0;
      resp_data     <= 8'h00;
      id_mode       <= 1'b0;
      erase_active  <= 1'b0;
      hv_level      <= 1'b0;
    end else begin
      case (state_reg)
        H_IDLE: begin
          ready <= 1'b1;
          if (req_valid && ready) begin
            ready    <= 1'b0;
            op_reg   <= req_op;
            addr_reg <= req_addr;
            data_reg <= req_data;
            rd_reg   <= req_read;
            step_reg <= 3'h0;
            if (req_read) begin
              // [R2] high-voltage id read
              hv_level      <= req_hv_id;
              cyc_wr_reg    <= 1'b0;
              cyc_addr_reg  <= req_addr;
              if (req_hv_id || id_mode) begin
                // [R4] [R5] [R6] [R7] function and sector bits
                cyc_addr_reg <= id_addr(req_addr);
                cyc_addr_reg[6] <= 1'b0;
              end
              start_reg <= 1'b1;
              state_reg <= H_WAIT;
            end else begin
              case (req_op)
                // [R10] suspend and resume only while erasing
                `FASC_OP_SUSPEND, `FASC_OP_RESUME: begin
                  if (erase_active &&
                      ((req_op == `FASC_OP_SUSPEND) != suspended_reg)) begin
                    cyc_wr_reg   <= 1'b1;
                    cyc_addr_reg <= req_addr;
                    cyc_data_reg <= (req_op == `FASC_OP_SUSPEND) ?
                                    `FASC_CMD_SUSPEND : `FASC_CMD_RESUME;
                    suspended_reg <= (req_op == `FASC_OP_SUSPEND);
                    start_reg    <= 1'b1;
                    state_reg    <= H_WAIT;
                  end else begin
                    resp_refused <= 1'b1;
                    resp_valid   <= 1'b1;
                    state_reg    <= H_IDLE;
                  end
                end
                // [R13] single return-to-read write
                `FASC_OP_READ_RESET, `FASC_OP_READ: begin
                  cyc_wr_reg    <= 1'b1;
                  cyc_addr_reg  <= req_addr;
                  cyc_data_reg  <= `FASC_CMD_READ_RESET;
                  // [R17] leaving id mode only here
                  id_mode       <= 1'b0;
                  erase_active  <= 1'b0;
                  suspended_reg <= 1'b0;
                  start_reg     <= 1'b1;
                  state_reg     <= H_WAIT;
                end
                default: begin
                  // [R3] [R8] [R9] [R14] multi-write sequences
                  nsteps_reg <= (req_op == `FASC_OP_AUTOSEL) ? 3'h3 :
                                (req_op == `FASC_OP_PROGRAM) ? 3'h4 : 3'h6;
                  state_reg  <= H_SEQ;
                end
              endcase
            end
          end
        end
        H_SEQ: begin
          if (!cyc_busy && !start_reg) begin
            // [R12] unlock addresses use low twelve bits only
            cyc_wr_reg   <= 1'b1;
            cyc_addr_reg <= cur_step[AW+7:8];
            cyc_data_reg <= cur_step[7:0];
            start_reg    <= 1'b1;
            state_reg    <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (cyc_done) begin
            hv_level <= 1'b0;
            if (rd_reg) begin
              // [R1] code or array byte handed back
              resp_data  <= cyc_rdata;
              resp_valid <= 1'b1;
              state_reg  <= H_IDLE;
            end else if (nsteps_reg != 3'h0 &&
                         step_reg != nsteps_reg - 3'h1) begin
              step_reg  <= step_reg + 3'h1;
              state_reg <= H_SEQ;
            end else begin
              if (op_reg == `FASC_OP_AUTOSEL)
                id_mode <= 1'b1;
              if (op_reg == `FASC_OP_SECT_ERASE ||
                  op_reg == `FASC_OP_CHIP_ERASE) begin
                erase_active  <= (op_reg == `FASC_OP_SECT_ERASE);
                suspended_reg <= 1'b0;
              end
              nsteps_reg <= 3'h0;
              resp_valid <= 1'b1;
              state_reg  <= H_IDLE;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule

// *** rtl/fasc_regs.vh ***
// Purpose: constants for the flash command host controller
// Assumes: byte-wide parallel nor flash with unlock command sequences
// Notes:   addresses are the low twelve command bits
`ifndef FASC_REGS_VH
`define FASC_REGS_VH
`define FASC_UNLOCK_ADDR1   12'h555
`define FASC_UNLOCK_ADDR2   12'h2AA
`define FASC_UNLOCK_DATA1   8'hAA
`define FASC_UNLOCK_DATA2   8'h55
`define FASC_CMD_AUTOSEL    8'h90
`define FASC_CMD_PROGRAM    8'hA0
`define FASC_CMD_ERASE_SET  8'h80
`define FASC_CMD_CHIP_ERASE 8'h10
`define FASC_CMD_SECT_ERASE 8'h30
`define FASC_CMD_SUSPEND    8'hB0
`define FASC_CMD_RESUME     8'h30
`define FASC_CMD_READ_RESET 8'hF0
`define FASC_ID_MANUF_ADDR  2'h0
`define FASC_ID_DEVICE_ADDR 2'h1
`define FASC_ID_PROT_ADDR   2'h2
`define FASC_PROT_YES       8'h01
`define FASC_PROT_NO        8'h00
`define FASC_SECT_MSB       18
`define FASC_SECT_LSB       13
`define FASC_OP_READ        3'h0
`define FASC_OP_PROGRAM     3'h1
`define FASC_OP_SECT_ERASE  3'h2
`define FASC_OP_CHIP_ERASE  3'h3
`define FASC_OP_AUTOSEL     3'h4
`define FASC_OP_SUSPEND     3'h5
`define FASC_OP_RESUME      3'h6
`define FASC_OP_READ_RESET  3'h7
`define FASC_ACCESS_NS      120
`define FASC_CLK_NS         40
`define FASC_ACCESS_CYC     ((`FASC_ACCESS_NS + `FASC_CLK_NS - 1) / `FASC_CLK_NS)
`endif

// *** tb/fasc_flash_model.sv ***
// Purpose: behavioural flash device facing the host controller
// Assumes: commands latched at the rising write strobe
// Notes:   released data bus shows the inverse of the last byte
module fasc_flash_model #(
  parameter MANUF_ID = 8'h3C, // arbitrary value
  parameter DEV_ID   = 8'hA7  // arbitrary value
) (
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        hv_level,
  input  wire [18:0] addr,
  input  wire [7:0]  din,
  output wire [7:0]  dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] wa;
  logic [18:0] pa   = 19'h7FFFF;
  logic [7:0]  wd;
  logic [7:0]  pd   = 8'h00;
  logic [7:0]  rv;
  logic [7:0]  last = 8'h00;
  logic [5:0]  sect = 6'h00;
  logic [2:0]  step = 3'h0;
  logic [2:0]  nx;
  logic        u1, u2;
  logic        idm  = 1'h0;
  logic        ers  = 1'h0;
  logic        susp = 1'h0;
  logic        chip = 1'h0;
  logic        pgm  = 1'h0;
  always @* if (!we_n && !cs_n) begin
    wa = addr;
    wd = din;
  end
  always @(posedge we_n) begin
    u1 = wa[11:0] == 12'h555;
    u2 = wa[11:0] == 12'h2AA;
    nx = 3'h0;
    if (pgm) begin
      pa  = wa;
      pd  = wd;
      pgm = 1'h0;
    end else if (wd == 8'hF0) begin
      idm  = 1'h0;
      ers  = 1'h0;
      susp = 1'h0;
    end else if (step == 3'h0 && ers && wd == 8'hB0) begin
      susp = 1'h1;
    end else if (step == 3'h0 && susp && wd == 8'h30) begin
      susp = 1'h0;
    end else case (step)
      3'h0: if (u1 && wd == 8'hAA) nx = 3'h1;
      3'h1: if (u2 && wd == 8'h55) nx = 3'h2;
      3'h2: begin
        idm = idm | (u1 && wd == 8'h90);
        pgm = u1 && wd == 8'hA0;
        if (u1 && wd == 8'h80) nx = 3'h3;
      end
      3'h3: if (u1 && wd == 8'hAA) nx = 3'h4;
      3'h4: if (u2 && wd == 8'h55) nx = 3'h5;
      default: begin
        chip = chip | (u1 && wd == 8'h10);
        if (wd == 8'h30) begin
          ers  = 1'h1;
          sect = wa[18:13];
        end
      end
    endcase
    step = nx;
  end
  always @* begin
    if (idm || (hv_level && !addr[6]))
      case (addr[1:0])
        2'h0: rv = MANUF_ID;
        2'h1: rv = DEV_ID;
        2'h2: rv = {7'h00, ^addr[18:13]};
        default: rv = 8'h00;
      endcase
    else rv = (addr == pa) ? pd : addr[7:0] ^ addr[15:8];
    if (!cs_n && !oe_n) last = rv;
  end
  assign dq = (!cs_n && !oe_n) ? rv : ~last;
endmodule

// *** tb/fasc_host_assertions.sv ***
// Purpose: port checks for the flash host controller
// Assumes: strobes held low for HOLD = 3 clocks
// Notes:   bound into every fasc_host instance
module fasc_host_chk #(
  parameter AW   = 19,
  parameter HOLD = 3
) (
  input wire          ref_clk,
  input wire          reset,
  input wire          req_valid,
  input wire [2:0]    req_op,
  input wire          req_read,
  input wire          ready,
  input wire          resp_valid,
  input wire          resp_refused,
  input wire          id_mode,
  input wire          erase_active,
  input wire [AW-1:0] flash_addr,
  input wire          dq_oe_n,
  input wire          cs_n,
  input wire          oe_n,
  input wire          we_n,
  input wire          hv_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_WR_PINS: assert property (!we_n |-> !cs_n && oe_n && !dq_oe_n)
    else $error("write strobe without select or with gate low");
  AST_RD_PINS: assert property (!oe_n |-> !cs_n && we_n && dq_oe_n)
    else $error("read gate with write strobe or data driven");
  AST_WR_LEN: assert property ($fell(we_n) |-> (!we_n)[*3] ##1 we_n)
    else $error("write strobe length wrong");
  AST_RD_LEN: assert property ($fell(oe_n) |-> (!oe_n)[*3] ##1 oe_n)
    else $error("read gate length wrong");
  AST_HV_A6: assert property (hv_level && !oe_n |-> !flash_addr[6])
    else $error("high voltage read with address bit 6 high");
  AST_HV_RD: assert property (hv_level |-> we_n)
    else $error("high voltage during a write");
  AST_ID_ADDR: assert property ((id_mode || hv_level) && !oe_n
    |-> flash_addr[12:2] == 11'h000)
    else $error("id read carries stray middle address bits");
  AST_REFUSE: assert property (ready && req_valid && !req_read
    && req_op == 3'h5 && !erase_active |-> ##[1:2] resp_refused)
    else $error("suspend outside erase not refused");
  AST_REF_PULSE: assert property (resp_refused |-> resp_valid)
    else $error("refusal without response");
endmodule
bind fasc_host fasc_host_chk #(.AW(AW), .HOLD(HOLD)) i_chk (
  .ref_clk      (ref_clk),
  .reset        (reset),
  .req_valid    (req_valid),
  .req_op       (req_op),
  .req_read     (req_read),
  .ready        (ready),
  .resp_valid   (resp_valid),
  .resp_refused (resp_refused),
  .id_mode      (id_mode),
  .erase_active (erase_active),
  .flash_addr   (flash_addr),
  .dq_oe_n      (dq_oe_n),
  .cs_n         (cs_n),
  .oe_n         (oe_n),
  .we_n         (we_n),
  .hv_level     (hv_level)
);

// *** tb/test_flash_autoselect_cmd_decoder.sv ***
// Purpose: self-checking bench for the flash host controller
// Assumes: HOLD of 3 clocks, seeded random addresses
// Notes:   expected bytes come from bench functions
module test_flash_autoselect_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] MID = 8'h3C; // arbitrary value
  localparam [7:0] DID = 8'hA7; // arbitrary value
  logic        ref_clk = 1'h0, reset = 1'h1, req_valid = 1'h0;
  logic        req_read = 1'h0, req_hv_id = 1'h0, rf;
  logic [2:0]  req_op = 3'h0;
  logic [18:0] req_addr = 19'h00000, a, tpa = 19'h7FFFF;
  logic [7:0]  req_data = 8'h00, rd, tpd = 8'h00;
  wire         ready, resp_valid, resp_refused, id_mode, erase_active;
  wire         dq_oe_n, cs_n, oe_n, we_n, hv_level;
  wire  [7:0]  resp_data, dq_out, mdq, bus;
  wire  [18:0] flash_addr;
  int          n_fail = 0, checks_done = 0;
  assign bus = dq_oe_n ? mdq : dq_out;
  fasc_host #(.AW(19), .HOLD(3)) i_fasc_host (.ref_clk(ref_clk),
    .reset(reset), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_read(req_read),
    .req_hv_id(req_hv_id), .dq_in(bus), .ready(ready),
    .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_refused(resp_refused), .id_mode(id_mode),
    .erase_active(erase_active), .flash_addr(flash_addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .hv_level(hv_level));
  fasc_flash_model #(.MANUF_ID(MID), .DEV_ID(DID)) i_fasc_flash_model (
    .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .hv_level(hv_level),
    .addr(flash_addr), .din(bus), .dq(mdq));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, held for one clock once ready is high, then wait for its response
  task automatic req(input logic [2:0] op, input logic [18:0] ad,
                     input logic [7:0] dt, input logic r, input logic hv);
    int n;
    n = 0;
    while (ready !== 1'h1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_op    <= op;
    req_addr  <= ad;
    req_data  <= dt;
    req_read  <= r;
    req_hv_id <= hv;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (resp_valid !== 1'h1 && n < 200);
    rd = resp_data;
    rf = resp_refused;
  endtask
  function automatic logic [7:0] exp_id(input logic [18:0] x);
    case (x[1:0])
      2'h0: return MID;
      2'h1: return DID;
      2'h2: return {7'h00, ^x[18:13]};
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] exp_arr(input logic [18:0] x);
    return (x == tpa) ? tpd : x[7:0] ^ x[15:8];
  endfunction
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h03F2));
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    // sector bits ride on the top lines, low bits pick the code
    for (int i = 0; i < 9; i++) begin
      a = $urandom;
      a[1:0] = i % 3;
      req(3'h0, a, 8'h00, 1'h1, 1'h1);
      chk(rd, exp_id(a));
    end
    $display("test hv_id done");
    req(3'h4, $urandom, 8'h00, 1'h0, 1'h0);
    chk(id_mode, 1'h1);
    for (int i = 0; i < 9; i++) begin
      a = $urandom;
      a[1:0] = i % 3;
      req(3'h0, a, 8'h00, 1'h1, 1'h0);
      chk(rd, exp_id(a));
    end
    req(3'h7, $urandom, 8'h00, 1'h0, 1'h0);
    chk(id_mode, 1'h0);
    a = $urandom;
    req(3'h0, a, 8'h00, 1'h1, 1'h0);
    chk(rd, exp_arr(a));
    $display("test cmd_id done");
    repeat (4) begin
      tpa = $urandom;
      tpd = $urandom;
      req(3'h1, tpa, tpd, 1'h0, 1'h0);
      req(3'h0, tpa, 8'h00, 1'h1, 1'h0);
      chk(rd, tpd);
      a = tpa ^ 19'h40000;
      req(3'h0, a, 8'h00, 1'h1, 1'h0);
      chk(rd, exp_arr(a));
    end
    $display("test program done");
    req(3'h5, $urandom, 8'h00, 1'h0, 1'h0);
    chk(rf, 1'h1);
    a = $urandom;
    req(3'h2, a, 8'h00, 1'h0, 1'h0);
    chk(erase_active, 1'h1);
    chk(i_fasc_flash_model.sect, a[18:13]);
    req(3'h6, $urandom, 8'h00, 1'h0, 1'h0);
    chk(rf, 1'h1);
    req(3'h5, $urandom, 8'h00, 1'h0, 1'h0);
    chk({rf, i_fasc_flash_model.susp}, 2'h1);
    req(3'h5, $urandom, 8'h00, 1'h0, 1'h0);
    chk(rf, 1'h1);
    req(3'h6, $urandom, 8'h00, 1'h0, 1'h0);
    chk({rf, i_fasc_flash_model.susp}, 2'h0);
    req(3'h0, $urandom, 8'h00, 1'h0, 1'h0);
    chk(erase_active, 1'h0);
    req(3'h3, $urandom, 8'h00, 1'h0, 1'h0);
    chk(i_fasc_flash_model.chip, 1'h1);
    $display("test erase done");
    end_sim;
  end
endmodule
